// ### design/chcs_pkg.sv
// shared constants and carriers for the channel assess / sync / turnaround block
package chcs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets on the serial configuration port
    localparam logic [5:0]  CHCS_ADDR_STATUS  = 6'h13;
    localparam logic [5:0]  CHCS_ADDR_SYNC    = 6'h14;
    localparam logic [5:0]  CHCS_ADDR_TXC     = 6'h15;
    localparam logic [5:0]  CHCS_ADDR_RXC     = 6'h16;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and write masks
    localparam logic [7:0]  CHCS_THR_RESET    = 8'he0;      // -32 dB
    localparam logic [7:0]  CHCS_SIGNAL_AND_CHANNEL_STATUS_INVALID = 8'h80;      // -128, no estimate
    localparam logic [15:0] CHCS_SYNC_RESET   = 16'ha70f;
    localparam logic [15:0] CHCS_TXC_RESET    = 16'ha0ff;
    localparam logic [15:0] CHCS_RXC_RESET    = 16'h12e5;
    localparam logic [15:0] CHCS_RXC_WMASK    = 16'h3fff;   // bits 15:14 held at zero

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int          CHCS_THR_LSB      = 8;
    localparam int          CHCS_TURN_BIT     = 13;
    localparam int          CHCS_PWR_LSB      = 0;
    localparam int          CHCS_CUR_LSB      = 6;

    ////////////////////////////////////////////////////////////////////////////
    // timing: 4 ns clock, 16 us symbol
    localparam int          CHCS_CLK_PERIOD_PS = 4000;
    localparam int          CHCS_SYM_PERIOD_US = 16;
    localparam int          CHCS_SYM_CYC       = CHCS_SYM_PERIOD_US * 1000000 / CHCS_CLK_PERIOD_PS;
    localparam int          CHCS_TURN_SHORT_US = 128;
    localparam int          CHCS_TURN_LONG_US  = 192;
    localparam int          CHCS_TURN_SHORT_CYC = CHCS_TURN_SHORT_US * 1000000 / CHCS_CLK_PERIOD_PS;
    localparam int          CHCS_TURN_LONG_CYC  = CHCS_TURN_LONG_US * 1000000 / CHCS_CLK_PERIOD_PS;
    localparam logic [3:0]  CHCS_AVG_SYMS     = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // sync nibble codes
    localparam logic [3:0]  CHCS_NIB_SKIP     = 4'hf;
    localparam logic [3:0]  CHCS_NIB_ZERO     = 4'h0;

    typedef enum logic [1:0] {
        CHCS_TX_IDLE = 2'b00,
        CHCS_TX_WAIT = 2'b01,
        CHCS_TX_SYNC = 2'b10
    } chcs_tx_state_type;

    typedef enum logic {
        CHCS_SY_IDLE = 1'b0,
        CHCS_SY_SEND = 1'b1
    } chcs_sy_state_type;

    // one register access from the serial port decoder
    typedef struct packed {
        logic [5:0]  addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } chcs_reg_req_type;

    // one symbol with its strobe
    typedef struct packed {
        logic [3:0]  symbol;
        logic        valid;
    } chcs_sym_type;

endpackage : chcs_pkg

// ### design/chcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module chcs_sync (
    input  wire logic                  clk,            // system clock
    input  wire logic                  rst_b,          // sync reset, active low
    input  wire logic                  sym_tick,       // one pulse per symbol
    input  wire logic [15:0]           pattern,        // frame sync pattern
    input  wire logic                  tx_go,          // start sending the pattern
    output logic                       tx_busy,        // pattern being sent
    output chcs_pkg::chcs_sym_type     tx_sym,         // sent symbol, registered
    input  wire chcs_pkg::chcs_sym_type rx_sym,        // received symbol
    output logic                       frame_sync_found // pulse, registered
);
    import chcs_pkg::*;

    typedef struct packed {
        chcs_sy_state_type st;
        logic [1:0]        idx;
        logic [15:0]       pat;
        chcs_sym_type      out;
        logic [4:0][3:0]   hist;   // [0] newest
        logic              found;
    } chcs_sy_reg_type;

    chcs_sy_reg_type st_r;
    chcs_sy_reg_type st_nxt;

    // skip nibbles are don't-care; a zero must precede the first demanded one
    function automatic logic chcs_match(logic [4:0][3:0] h, logic [15:0] p);
        logic       ok;
        logic       zero_done;
        logic [3:0] nib;
        ok        = 1'b1;
        zero_done = 1'b0;
        for (int i = 0; i < 4; i++) begin
            nib = p[4*i +: 4];
            if (nib != CHCS_NIB_SKIP) begin
                if (!zero_done && h[4-i] != CHCS_NIB_ZERO) begin
                    ok = 1'b0;
                end
                zero_done = 1'b1;
                if (h[3-i] != nib) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction : chcs_match

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [3:0] nib;
        st_nxt           = st_r;
        st_nxt.out.valid = 1'b0;
        st_nxt.found     = 1'b0;
        nib              = st_r.pat[{st_r.idx, 2'b00} +: 4];
        unique case (st_r.st)
            CHCS_SY_IDLE: begin
                if (tx_go) begin
                    st_nxt.st  = CHCS_SY_SEND;
                    st_nxt.idx = 2'b00;
                    st_nxt.pat = pattern;   // latched so a rewrite mid-frame is harmless
                end
            end
            CHCS_SY_SEND: begin
                if (sym_tick) begin
                    // low nibble first skip nibbles go out as zero
                    st_nxt.out.symbol = (nib == CHCS_NIB_SKIP) ? CHCS_NIB_ZERO : nib;
                    st_nxt.out.valid  = 1'b1;
                    st_nxt.idx        = st_r.idx + 2'b01;
                    if (st_r.idx == 2'b11) begin
                        st_nxt.st = CHCS_SY_IDLE;
                    end
                end
            end
        endcase
        // receive history and match
        if (rx_sym.valid) begin
            st_nxt.hist  = {st_r.hist[3:0], rx_sym.symbol};
            st_nxt.found = chcs_match({st_r.hist[3:0], rx_sym.symbol}, pattern);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r      <= '0;
            st_r.hist <= {5{CHCS_NIB_SKIP}};   // non-zero fill blocks a false match
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_busy          = (st_r.st == CHCS_SY_SEND);
    assign tx_sym           = st_r.out;
    assign frame_sync_found = st_r.found;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_go_taken;
        tx_go && !tx_busy;
    endsequence

    sequence s_first_nibble;
        tx_busy && st_r.idx == 2'b00 && st_r.pat == $past(pattern);
    endsequence

    a_tx_start_order: assert property (s_go_taken |=> s_first_nibble)
        else $error("pattern send did not start at the low nibble");

    a_tx_skip_zero: assert property (tx_sym.valid |->
        tx_sym.symbol == ((st_r.pat[{st_r.idx - 2'b01, 2'b00} +: 4] == CHCS_NIB_SKIP)
                          ? CHCS_NIB_ZERO : st_r.pat[{st_r.idx - 2'b01, 2'b00} +: 4]))
        else $error("sent symbol does not follow the pattern nibble");

    a_rx_zero_first: assert property (frame_sync_found |->
        chcs_match(st_r.hist, $past(pattern)) && $past(rx_sym.valid))
        else $error("frame sync declared without a matching history");

endmodule : chcs_sync
`default_nettype wire

// ### design/chcs_top.sv
// Notes on behaviour
// - threshold is status bits 15:8, signed dB, resets to -32
// - clear-channel output high while estimate below threshold minus hysteresis
// - estimate byte is read-only, signed dB, average of last 8 symbols
// - valid bit rises only after receiver enabled for 8 symbol periods
// - estimate resets to -128, meaning no valid estimate
// - sync pattern resets to a70f, used lowest nibble first
// - transmitted sync nibble f becomes symbol zero
// - received sync nibble f is don't-care
// - a zero symbol must precede the first demanded sync symbol
// - transmit waits 8 or 12 symbols after strobe; select resets to 1
// - power level bits 4:0 reset 31, amplifier current bits 8:6 reset 3
// - clear-channel set below threshold minus hysteresis, cleared at threshold
`timescale 1ns/1ps
`default_nettype none
module chcs_top #(
    parameter int TURN_SHORT_CYC = chcs_pkg::CHCS_TURN_SHORT_CYC,  // 8 symbol wait
    parameter int TURN_LONG_CYC  = chcs_pkg::CHCS_TURN_LONG_CYC    // 12 symbol wait
) (
    input  wire logic                     clk,                      // 250 MHz
    input  wire logic                     rst_b,                    // sync reset, active low
    input  wire chcs_pkg::chcs_reg_req_type reg_req,                // decoded port access
    output logic [15:0]                   reg_rdata,                // read data, registered
    input  wire logic                     rx_enable,                // receiver running
    input  wire logic [7:0]               signal_and_channel_status_sample,              // per-symbol level, signed
    input  wire logic [2:0]               clear_channel_hysteresis, // dB
    input  wire logic                     transmit_on_strobe,       // start transmit
    input  wire chcs_pkg::chcs_sym_type   rx_sym,                   // demodulated symbol
    output logic                          clear_channel_indication, // pin, registered
    output logic                          signal_strength_valid,    // estimate usable
    output logic [4:0]                    output_power_level,       // from register
    output logic [2:0]                    amplifier_current_adjust, // from register
    output logic                          tx_start_delay_select,    // from register
    output logic                          tx_start,                 // pulse, wait over
    output logic                          tx_busy,                  // wait or sync send
    output chcs_pkg::chcs_sym_type        tx_sym,                   // modulator symbol
    output logic                          frame_sync_found          // pulse
);
    import chcs_pkg::*;

    typedef struct packed {
        logic [7:0]        thr;
        logic [7:0]        signal_and_channel_status;
        logic [15:0]       sync;
        logic [15:0]       txc;
        logic [15:0]       rxc;
        logic [15:0]       rdata;
        logic [11:0]       sym_cnt;
        logic              sym_tick;
        logic [7:0][7:0]   samples;   // [0] newest
        logic [3:0]        en_syms;
        logic              cca;
        chcs_tx_state_type tx_state;
        logic [15:0]       turn_cnt;
        logic              tx_go;
    } chcs_top_reg_type;

    chcs_top_reg_type st_r;
    chcs_top_reg_type st_nxt;
    logic             sync_busy;

    // sign extend a dB byte for comparisons that may underflow
    function automatic logic signed [9:0] chcs_sx(logic [7:0] v);
        return $signed({{2{v[7]}}, v});
    endfunction : chcs_sx

    // floor mean of eight signed samples
    function automatic logic [7:0] chcs_avg(logic [7:0][7:0] s);
        logic signed [10:0] acc;
        acc = '0;
        for (int i = 0; i < 8; i++) begin
            acc = acc + $signed({{3{s[i][7]}}, s[i]});
        end
        return acc[10:3];
    endfunction : chcs_avg

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [7:0][7:0]    smp;
        logic [3:0]         cnt;
        logic signed [9:0]  lo;
        st_nxt          = st_r;
        st_nxt.sym_tick = 1'b0;
        st_nxt.tx_go    = 1'b0;
        smp             = {st_r.samples[6:0], signal_and_channel_status_sample};
        cnt             = st_r.en_syms;
        lo              = chcs_sx(st_r.thr) - $signed({7'h00, clear_channel_hysteresis});

        // symbol divider: one enable pulse every symbol period
        if (st_r.sym_cnt == 12'(CHCS_SYM_CYC - 1)) begin
            st_nxt.sym_cnt  = '0;
            st_nxt.sym_tick = 1'b1;
        end else begin
            st_nxt.sym_cnt = st_r.sym_cnt + 12'h001;
        end

        // estimate: first tick may be a partial symbol, so count one extra
        if (!rx_enable) begin
            st_nxt.en_syms = '0;
            st_nxt.signal_and_channel_status    = CHCS_SIGNAL_AND_CHANNEL_STATUS_INVALID;
        end else if (st_r.sym_tick) begin
            st_nxt.samples = smp;
            if (cnt <= CHCS_AVG_SYMS) begin
                cnt = cnt + 4'h1;
            end
            st_nxt.en_syms = cnt;
            st_nxt.signal_and_channel_status    = (cnt > CHCS_AVG_SYMS) ? chcs_avg(smp)
                                                   : CHCS_SIGNAL_AND_CHANNEL_STATUS_INVALID;
        end

        // clear-channel with hysteresis; hysteresis 0 is a plain threshold
        if (chcs_sx(st_r.signal_and_channel_status) < lo) begin
            st_nxt.cca = 1'b1;
        end else if (chcs_sx(st_r.signal_and_channel_status) >= chcs_sx(st_r.thr)) begin
            st_nxt.cca = 1'b0;
        end

        // transmit turnaround; strobes while busy are dropped
        unique case (st_r.tx_state)
            CHCS_TX_IDLE: begin
                if (transmit_on_strobe) begin
                    st_nxt.tx_state = CHCS_TX_WAIT;
                    st_nxt.turn_cnt = st_r.txc[CHCS_TURN_BIT]
                                    ? 16'(TURN_LONG_CYC - 2) : 16'(TURN_SHORT_CYC - 2);
                end
            end
            CHCS_TX_WAIT: begin
                if (st_r.turn_cnt == 16'h0000) begin
                    st_nxt.tx_state = CHCS_TX_SYNC;
                    st_nxt.tx_go    = 1'b1;
                end else begin
                    st_nxt.turn_cnt = st_r.turn_cnt - 16'h0001;
                end
            end
            CHCS_TX_SYNC: begin
                if (!st_r.tx_go && !sync_busy) begin
                    st_nxt.tx_state = CHCS_TX_IDLE;
                end
            end
            default: begin
                st_nxt.tx_state = CHCS_TX_IDLE;
            end
        endcase

        // register writes
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                CHCS_ADDR_STATUS: st_nxt.thr  = reg_req.wdata[15:CHCS_THR_LSB];
                CHCS_ADDR_SYNC:   st_nxt.sync = reg_req.wdata;
                CHCS_ADDR_TXC:    st_nxt.txc  = reg_req.wdata;
                CHCS_ADDR_RXC:    st_nxt.rxc  = reg_req.wdata & CHCS_RXC_WMASK;
                default: ;
            endcase
        end

        // register reads, unmapped offsets give zero
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                CHCS_ADDR_STATUS: st_nxt.rdata = {st_r.thr, st_r.signal_and_channel_status};
                CHCS_ADDR_SYNC:   st_nxt.rdata = st_r.sync;
                CHCS_ADDR_TXC:    st_nxt.rdata = st_r.txc;
                CHCS_ADDR_RXC:    st_nxt.rdata = st_r.rxc;
                default:          st_nxt.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r      <= '0;
            st_r.thr  <= CHCS_THR_RESET;
            st_r.signal_and_channel_status <= CHCS_SIGNAL_AND_CHANNEL_STATUS_INVALID;
            st_r.sync <= CHCS_SYNC_RESET;
            st_r.txc  <= CHCS_TXC_RESET;
            st_r.rxc  <= CHCS_RXC_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync pattern engine
    chcs_sync u_sync (
        .clk              (clk),
        .rst_b            (rst_b),
        .sym_tick         (st_r.sym_tick),
        .pattern          (st_r.sync),
        .tx_go            (st_r.tx_go),
        .tx_busy          (sync_busy),
        .tx_sym           (tx_sym),
        .rx_sym           (rx_sym),
        .frame_sync_found (frame_sync_found)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata                = st_r.rdata;
    assign clear_channel_indication = st_r.cca;
    assign signal_strength_valid    = (st_r.en_syms > CHCS_AVG_SYMS);
    assign output_power_level       = st_r.txc[CHCS_PWR_LSB +: 5];
    assign amplifier_current_adjust = st_r.txc[CHCS_CUR_LSB +: 3];
    assign tx_start_delay_select    = st_r.txc[CHCS_TURN_BIT];
    assign tx_start                 = st_r.tx_go;
    assign tx_busy                  = (st_r.tx_state != CHCS_TX_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // helper: cycles spent waiting and the select taken with the strobe
    logic [15:0] chk_wait_r;
    logic        chk_sel_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chk_wait_r <= '0;
            chk_sel_r  <= 1'b0;
        end else if (st_r.tx_state == CHCS_TX_IDLE) begin
            chk_wait_r <= '0;
            chk_sel_r  <= st_r.txc[CHCS_TURN_BIT];
        end else if (st_r.tx_state == CHCS_TX_WAIT) begin
            chk_wait_r <= chk_wait_r + 16'h0001;
        end
    end

    a_turn_delay: assert property (tx_start |->
        chk_wait_r == (chk_sel_r ? 16'(TURN_LONG_CYC - 1) : 16'(TURN_SHORT_CYC - 1)))
        else $error("transmit started after the wrong wait");

    a_cca_below: assert property (
        chcs_sx(st_r.signal_and_channel_status) < chcs_sx(st_r.thr) - $signed({7'h00, clear_channel_hysteresis})
        |=> clear_channel_indication)
        else $error("clear-channel low with estimate under threshold");

    a_cca_at_thr: assert property (
        chcs_sx(st_r.signal_and_channel_status) >= chcs_sx(st_r.thr) |=> !clear_channel_indication)
        else $error("clear-channel high at or above threshold");

    a_signal_and_channel_status_invalid: assert property (
        !signal_strength_valid |-> st_r.signal_and_channel_status == CHCS_SIGNAL_AND_CHANNEL_STATUS_INVALID)
        else $error("estimate shown before it is valid");

    a_valid_drop: assert property (
        !rx_enable ##1 rx_enable [*8] |-> !signal_strength_valid)
        else $error("valid bit set too soon after enable");

    a_signal_and_channel_status_avg: assert property (
        rx_enable && st_r.sym_tick && $past(signal_strength_valid) && signal_strength_valid
        |=> st_r.signal_and_channel_status == chcs_avg($past(st_nxt.samples)))
        else $error("estimate is not the mean of the last eight samples");

    a_thr_write: assert property (
        reg_req.wr && reg_req.addr == CHCS_ADDR_STATUS && !st_r.sym_tick && rx_enable
        |=> st_r.thr == $past(reg_req.wdata[15:8]) && $stable(st_r.signal_and_channel_status))
        else $error("status write changed the wrong byte");

    a_txc_fields: assert property (
        reg_req.wr && reg_req.addr == CHCS_ADDR_TXC
        |=> output_power_level == $past(reg_req.wdata[4:0])
            && amplifier_current_adjust == $past(reg_req.wdata[8:6]))
        else $error("transmit control fields not taken from the write");

    a_rxc_reserved: assert property (st_r.rxc[15:14] == 2'b00)
        else $error("receive control reserved bits not zero");

    // helper: cycles since the receiver was enabled, saturating so it never wraps
    logic [16:0] chk_en_r;
    always_ff @(posedge clk) begin
        if (!rst_b || !rx_enable) begin
            chk_en_r <= '0;
        end else if (chk_en_r != 17'h1ffff) begin
            chk_en_r <= chk_en_r + 17'h00001;
        end
    end

    a_valid_late: assert property (
        signal_strength_valid |-> chk_en_r >= 17'(8 * CHCS_SYM_CYC))
        else $error("valid bit set before eight symbol periods");

    a_signal_and_channel_status_disabled: assert property (
        !rx_enable |=> !signal_strength_valid && st_r.signal_and_channel_status == CHCS_SIGNAL_AND_CHANNEL_STATUS_INVALID)
        else $error("estimate kept while the receiver is off");

    sequence s_strobe_taken;
        transmit_on_strobe && !tx_busy;
    endsequence

    a_strobe_wait: assert property (s_strobe_taken |=> tx_busy && !tx_start)
        else $error("strobe did not open the turnaround wait");

    a_start_pulse: assert property (tx_start |=> !tx_start)
        else $error("transmit start held longer than one cycle");

    a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

endmodule : chcs_top
`default_nettype wire

// ### dv/chcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the register port: one access per call, one idle cycle after
module chcs_host_model (
    input  wire logic                  clk, // system clock
    output var chcs_pkg::chcs_reg_req_type req  // decoded access
);
    import chcs_pkg::*;
    initial req = '0;
    ////////////////////////////////////////////////////////////////////////////
    // request set just after an edge, held through the taking edge
    task automatic access(input logic [5:0] a, input logic w, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (w && a == CHCS_ADDR_TXC) v[5] = 1'b1;
        if (w && a == CHCS_ADDR_RXC) v[15:14] = 2'b00;
        @(posedge clk);
        #1 req = '{addr: a, wr: w, rd: !w, wdata: v};
        @(posedge clk);
        // stale data is inverted so a late sample cannot pass by luck
        #1 req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
    endtask : access
endmodule : chcs_host_model
`default_nettype wire

// ### dv/channel_assess_sync_turnaround_tb.sv
`timescale 1ns/1ps
`default_nettype none
module channel_assess_sync_turnaround_tb;
    import chcs_pkg::*;
    logic clk, rst_b, rx_enable, strobe, cca, ssv, sel, tx_start, tx_busy, fsf, rd_d;
    logic [15:0] reg_rdata;
    logic [7:0] signal_and_channel_status_sample, v;
    logic [4:0] pwr;
    logic [2:0] cur, hyst;
    chcs_reg_req_type reg_req;
    chcs_sym_type rx_sym, tx_sym;
    logic [15:0] expq[$];
    logic [31:0] seed;
    int failures = 0, n_compared = 0, n_found = 0, n;
    chcs_host_model host (.clk(clk), .req(reg_req));
    chcs_top #(.TURN_SHORT_CYC(20), .TURN_LONG_CYC(30)) dut (.clk(clk), .rst_b(rst_b),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_enable(rx_enable),
        .signal_and_channel_status_sample(signal_and_channel_status_sample), .clear_channel_hysteresis(hyst),
        .transmit_on_strobe(strobe), .rx_sym(rx_sym), .clear_channel_indication(cca),
        .signal_strength_valid(ssv), .output_power_level(pwr),
        .amplifier_current_adjust(cur), .tx_start_delay_select(sel), .tx_start(tx_start),
        .tx_busy(tx_busy), .tx_sym(tx_sym), .frame_sync_found(fsf));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic end_of_test();
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        expq.push_back(e);
        host.access(a, 1'b0, 16'h0000);
    endtask : rd
    task automatic sym(input logic [3:0] s);
        @(posedge clk);
        #1 rx_sym = '{symbol: s, valid: 1'b1};
        @(posedge clk);
        #1 rx_sym = '{symbol: ~s, valid: 1'b0};
    endtask : sym
    task automatic pulse();
        @(posedge clk);
        #1 strobe = 1'b1;
        @(posedge clk);
        #1 strobe = 1'b0;
    endtask : pulse
    // bounded wait: 0 estimate valid, 1 turnaround over, 2 transmitter idle
    task automatic wait_for(input int which, input int lim, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (!(which == 0 ? ssv === 1'b1 : which == 1 ? tx_start === 1'b1
                     : tx_busy === 1'b0) && k < lim);
        if (k >= lim) begin
            failures++;
            end_of_test();
        end
    endtask : wait_for
    ////////////////////////////////////////////////////////////////////////////
    // monitor: a read answer or a sent symbol takes the oldest expectation
    always @(posedge clk) begin
        rd_d <= reg_req.rd;
        if (rd_d === 1'b1) check(reg_rdata, expq.size() > 0 ? expq.pop_front() : 'x);
        if (tx_sym.valid === 1'b1)
            check({12'h000, tx_sym.symbol}, expq.size() > 0 ? expq.pop_front() : 'x);
        if (fsf === 1'b1) n_found++;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0; rx_enable = 1'b0; signal_and_channel_status_sample = 8'h00; strobe = 1'b0; rx_sym = '0;
        hyst = 3'h0;
        seed = 32'h616100cb;
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        rd(CHCS_ADDR_STATUS, 16'he080);
        rd(CHCS_ADDR_SYNC, 16'ha70f);
        rd(CHCS_ADDR_TXC, 16'ha0ff);
        rd(CHCS_ADDR_RXC, 16'h12e5);
        rd(6'h20, 16'h0000);
        host.access(CHCS_ADDR_RXC, 1'b1, 16'hffff);
        rd(CHCS_ADDR_RXC, 16'h3fff);
        check({7'h00, pwr, cur, sel}, {7'h00, 5'h1f, 3'h3, 1'b1});
        // constant level keeps the 8-symbol mean equal to the sample
        seed = lfsr(lfsr(seed));
        v = seed[7:0];
        signal_and_channel_status_sample = v;
        hyst = seed[10:8];
        rx_enable = 1'b1;
        wait_for(0, 40000, n);
        check({15'h0, n >= 8 * 4000}, 16'h0001);
        repeat (2) @(posedge clk);
        #1 check({15'h0, cca}, {15'h0, $signed(v) < $signed(8'he0)});
        rd(CHCS_ADDR_STATUS, {8'he0, v});
        host.access(CHCS_ADDR_STATUS, 1'b1, 16'h1234);
        rd(CHCS_ADDR_STATUS, {8'h12, v});
        // inside the band under the new threshold the old low value is kept
        check({15'h0, cca}, {15'h0, int'($signed(v)) < 18 - int'(hyst)});
        rx_enable = 1'b0;
        repeat (3) @(posedge clk);
        #1 check({14'h0, ssv, cca}, 16'h0001);
        rd(CHCS_ADDR_STATUS, 16'h1280);
        // wrong symbol where the implicit zero belongs, then a good frame
        // the found pulse is counted by the monitor one edge after the last symbol
        for (int i = 0; i < 4; i++) sym(i == 0 ? 4'h5 : i == 1 ? 4'h0 : i == 2 ? 4'h7 : 4'ha);
        @(posedge clk);
        #1 check(n_found[15:0], 16'h0000);
        for (int i = 0; i < 4; i++) sym(i < 2 ? 4'h0 : i == 2 ? 4'h7 : 4'ha);
        @(posedge clk);
        #1 check(n_found[15:0], 16'h0001);
        host.access(CHCS_ADDR_TXC, 1'b1, 16'h81e5);
        check({7'h00, pwr, cur, sel}, {7'h00, 5'h05, 3'h7, 1'b0});
        expq = '{16'h0, 16'h0, 16'h7, 16'ha};
        pulse();
        wait_for(1, 100, n);
        // the count starts one edge after the strobe edge
        check(16'(n + 1), 16'd20);
        pulse();
        wait_for(2, 20100, n);
        repeat (3) @(posedge clk);
        #1 check({15'h0, tx_busy}, 16'h0000);
        host.access(CHCS_ADDR_SYNC, 1'b1, 16'h3f5f);
        host.access(CHCS_ADDR_TXC, 1'b1, 16'ha0ff);
        expq = '{16'h0, 16'h5, 16'h0, 16'h3};
        pulse();
        wait_for(1, 100, n);
        check(16'(n + 1), 16'd30);
        wait_for(2, 20100, n);
        for (int i = 0; i < 4; i++) sym(i == 0 ? 4'h0 : i == 1 ? 4'h5 : i == 2 ? 4'h9 : 4'h3);
        @(posedge clk);
        #1 check(n_found[15:0], 16'h0002);
        check(16'(expq.size()), 16'h0000);
        end_of_test();
    end
endmodule : channel_assess_sync_turnaround_tb
`default_nettype wire
